// >>> verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CLK_EN = 12'h050;
    localparam logic [11:0] OFF_CLK_DIS = 12'h054;
    localparam logic [11:0] OFF_CLK_STATE = 12'h058;
    localparam logic [11:0] OFF_COMMAND = 12'h060;
    localparam logic [11:0] OFF_CONFIG = 12'h064;
    localparam logic [11:0] OFF_SEQ_SEL = 12'h068;
    localparam logic [11:0] OFF_FLAG_CLR = 12'h06c;
    localparam logic [11:0] OFF_FLAG_STATE = 12'h070;
    localparam logic [11:0] OFF_IRQ_EN = 12'h074;
    localparam logic [11:0] OFF_IRQ_DIS = 12'h078;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h07c;
    localparam logic [11:0] OFF_RESULT = 12'h080;
    // Clock registers
    localparam int CLK_BIT = 1;
    // Command bits
    localparam int CMD_SOFT_RST = 0;
    localparam int CMD_AN_EN = 1;
    localparam int CMD_AN_DIS = 2;
    localparam int CMD_START = 3;
    localparam int CMD_STOP = 4;
    // Operating config fields
    localparam int CFG_PRL_LSB = 1;
    localparam int CFG_PRL_W = 5;
    localparam int CFG_TRANSFER_END_STOP_EN = 6;
    localparam int CFG_SETTLE_LSB = 8;
    localparam int CFG_SETTLE_W = 8;
    localparam int CFG_LEN_LSB = 16;
    localparam int CFG_LEN_W = 3;
    localparam int CFG_REPEAT = 19;
    localparam logic [31:0] CFG_MASK = 32'h000fff7e;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [31:0] SEQ_RESET = 32'h00000000;
    // Flag bits, shared by status and interrupt registers, FL_LOST and FL_TRANSFER_END_FLAG also by clear; FL_AN_ON and FL_REPEAT are status only
    localparam int FL_DONE = 0;
    localparam int FL_READY = 1;
    localparam int FL_LOST = 2;
    localparam int FL_TRANSFER_END_FLAG = 3;
    localparam int FL_AN_ON = 8;
    localparam int FL_REPEAT = 9;
    localparam int SLOT_STRIDE = 4;
    localparam int CHAN_W = 3;
    localparam int RES_W = 10;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_TIME_NS = 4000;
    localparam int SETTLE_MIN_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_CYC = 1;
    localparam int RESOLVE_CYC = 10;
    localparam int CONV_CYC = SAMPLE_CYC + RESOLVE_CYC;
    localparam int FIFO_DEPTH = 32;
endpackage : adc_ctrl_pkg

// >>> verilog/adc_sequencer_control.sv
// Functional notes
// RL1: Analog disable command puts analog part in standby; digital stays alive.
// RL2: Clock disable write stops the whole digital interface; the code still answers register reads.
// RL3: Clock enable write restarts the digital interface.
// RL4: After analog enable, count settle cycles (at least 4 us) then set ready.
// RL5: Ready is low when disabled or converting, high when settled and idle.
// RL6: Only an analog enable command launches the settle interval.
// RL7: Commands before ready are ignored without side effects; the code ignores start and stop then, not soft reset or analog disable.
// RL8: Analog enable from wait state returns the converter to active.
// RL9: Software disables analog before the clock to reach full standby.
// RL10: Repeat bit picks continuous or one-shot; resets to zero.
// RL11: Sequence length sets how many inputs each sequence converts.
// RL12: Software programs settle count and divider before any start.
// RL13: Sample one converter clock, then resolve over ten more.
// RL14: Eleven converter clocks after start, latch result and set done flag; the code waits in the store state while the FIFO is full.
// RL15: Any read of the result, by processor or transfer controller, clears done.
// RL16: A result latched while the previous is unread sets the lost flag.
// RL17: Transfer controller end-of-transfer sets the transfer-end flag.
// RL18: Each programmed slot repeats sample, resolve, latch and flag.
// RL19: Interrupt is raised when ready sets and its mask bit is on.
// RL20: Slot n input code sits in nibble n of the sequence select register.
// RL21: Writing one to a clear-register flag bit clears that flag.
// RL22: Results are unsigned codes from zero to 1023.
// RL23: Sequence length field holds conversions minus one.
// RL24: Soft reset command returns every register to reset state; the code leaves the clock state register (clk_on_q) as it is.
// RL25: Start begins a conversion and clears the done flag.
// RL26: In continuous mode with stop enable, transfer end halts conversions.
// RL27: Converter clock comes from a reloaded down counter, symmetric duty.
// RL28: Stop in continuous mode finishes and latches the current conversion; the code first runs on through the last slot of the sequence.
`timescale 1ns/1ps

module result_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_q];

    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
        begin
            count_d = count_q + 1'b1;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    // Flags registered to keep adders off ports
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else if (flush_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else
        begin
            wr_ptr_q <= push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
            rd_ptr_q <= pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
            count_q <= count_d;
            in_ready_o <= (count_d != (AW + 1)'(DEPTH));
            out_valid_o <= (count_d != '0);
        end
    end
endmodule : result_fifo

module adc_sequencer_control #(
    parameter int FIFO_WORDS = adc_ctrl_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Peripheral bus (APB)
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Transfer controller stream
    output logic result_valid_o,
    input wire logic result_ready_i,
    output logic [adc_ctrl_pkg::RES_W-1:0] result_data_o,
    input wire logic xfer_end_i,
    // Analog part
    output logic analog_standby_o,
    output logic adc_clk_o,
    output logic adc_start_o,
    output logic [adc_ctrl_pkg::CHAN_W-1:0] adc_chan_o,
    input wire logic [adc_ctrl_pkg::RES_W-1:0] adc_result_i,
    // Power and interrupt
    output logic periph_clk_en_o,
    output logic irq_o
);
    import adc_ctrl_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_CONV, S_STORE} seq_state_t;

    seq_state_t state_q;
    logic clk_on_q, an_on_q, settled_q, done_q, lost_q, transfer_end_flag_q, adc_clk_q;
    logic stop_req_q, pready_q, perr_q, irq_q;
    logic [7:0] settle_cnt_q;
    logic [31:0] cfg_q, seq_q, rdata_q;
    logic [RES_W-1:0] result_q, res_meta_q, res_sync_q;
    logic [3:0] irq_mask_q;
    logic [5:0] div_cnt_q;
    logic [3:0] conv_cnt_q;
    logic [CHAN_W-1:0] slot_q;

    logic wr_acc, rd_acc, cmd_wr, soft_rst, ready, start_ok, an_en_cmd, an_dis_cmd;
    logic adc_tick, last_slot, keep_going, latch, fifo_ready, tc_pop, result_rd, mapped;
    logic [3:0] flags;
    logic [5:0] div_reload;
    logic [7:0] settle_target;
    logic [CHAN_W-1:0] chan_sel [8];

    // Writes act at the access edge
    assign wr_acc = psel_i && penable_i && pwrite_i && pready_q;
    assign rd_acc = psel_i && penable_i && !pwrite_i && pready_q;
    assign cmd_wr = wr_acc && clk_on_q && (paddr_i == OFF_COMMAND);
    assign soft_rst = cmd_wr && pwdata_i[CMD_SOFT_RST]; // see RL24

    assign ready = settled_q && (state_q == S_IDLE); // see RL5
    assign an_en_cmd = cmd_wr && pwdata_i[CMD_AN_EN];
    assign an_dis_cmd = cmd_wr && pwdata_i[CMD_AN_DIS];
    // A disable in the same write cannot start
    assign start_ok = cmd_wr && pwdata_i[CMD_START] && ready && !pwdata_i[CMD_AN_DIS]; // see RL7

    assign flags = {transfer_end_flag_q, lost_q, ready, done_q};
    assign tc_pop = result_valid_o && result_ready_i && clk_on_q;
    assign result_rd = (rd_acc && clk_on_q && (paddr_i == OFF_RESULT)) || tc_pop; // see RL15

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_slot
            assign chan_sel[gi] = seq_q[gi*SLOT_STRIDE +: CHAN_W]; // see RL20
        end
    endgenerate

    always_comb
    begin
        mapped = 1'b1;
        unique case (paddr_i)
            OFF_CLK_EN, OFF_CLK_DIS, OFF_CLK_STATE, OFF_COMMAND, OFF_CONFIG,
            OFF_SEQ_SEL, OFF_FLAG_CLR, OFF_FLAG_STATE, OFF_IRQ_EN, OFF_IRQ_DIS,
            OFF_IRQ_MASK, OFF_RESULT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // No wait states; unmapped addresses get an error
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_q <= 1'b0;
            perr_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= psel_i && !penable_i;
            perr_q <= psel_i && !penable_i && !mapped;
            rdata_q <= 32'h00000000;
            if (psel_i && !penable_i && !pwrite_i)
            begin
                unique case (paddr_i)
                    OFF_CLK_STATE: rdata_q[CLK_BIT] <= clk_on_q;
                    OFF_CONFIG: rdata_q <= cfg_q;
                    OFF_SEQ_SEL: rdata_q <= seq_q;
                    OFF_FLAG_STATE:
                    begin
                        rdata_q[3:0] <= flags;
                        rdata_q[FL_AN_ON] <= an_on_q;
                        rdata_q[FL_REPEAT] <= cfg_q[CFG_REPEAT];
                    end
                    OFF_IRQ_MASK: rdata_q[3:0] <= irq_mask_q;
                    OFF_RESULT: rdata_q[RES_W-1:0] <= result_q; // see RL22
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Gates the digital part but not register reads; clock registers stay reachable
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            clk_on_q <= 1'b0;
        end
        else if (wr_acc && (paddr_i == OFF_CLK_DIS) && pwdata_i[CLK_BIT])
        begin
            clk_on_q <= 1'b0; // see RL2
        end
        else if (wr_acc && (paddr_i == OFF_CLK_EN) && pwdata_i[CLK_BIT])
        begin
            clk_on_q <= 1'b1; // see RL3
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_q <= CFG_RESET;
            seq_q <= SEQ_RESET;
            irq_mask_q <= 4'h0;
        end
        else if (soft_rst)
        begin
            cfg_q <= CFG_RESET; // see RL10
            seq_q <= SEQ_RESET;
            irq_mask_q <= 4'h0;
        end
        else if (wr_acc && clk_on_q)
        begin
            if (paddr_i == OFF_CONFIG)
            begin
                cfg_q <= pwdata_i & CFG_MASK;
            end
            if (paddr_i == OFF_SEQ_SEL)
            begin
                seq_q <= pwdata_i & 32'h77777777;
            end
            if (paddr_i == OFF_IRQ_EN)
            begin
                irq_mask_q <= irq_mask_q | pwdata_i[3:0];
            end
            if (paddr_i == OFF_IRQ_DIS)
            begin
                irq_mask_q <= irq_mask_q & ~pwdata_i[3:0];
            end
        end
    end

    // Never below the 4 us floor
    assign settle_target = (cfg_q[CFG_SETTLE_LSB +: CFG_SETTLE_W] > 8'(SETTLE_MIN_CYC))
        ? cfg_q[CFG_SETTLE_LSB +: CFG_SETTLE_W] : 8'(SETTLE_MIN_CYC);

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            an_on_q <= 1'b0;
            settled_q <= 1'b0;
            settle_cnt_q <= 8'h00;
        end
        else if (soft_rst)
        begin
            an_on_q <= 1'b0;
            settled_q <= 1'b0;
            settle_cnt_q <= 8'h00;
        end
        else if (an_dis_cmd)
        begin
            an_on_q <= 1'b0; // see RL1
            settled_q <= 1'b0;
        end
        else if (an_en_cmd && !an_on_q)
        begin
            an_on_q <= 1'b1; // see RL8
            settled_q <= 1'b0;
            settle_cnt_q <= settle_target - 8'h01; // see RL6
        end
        else if (clk_on_q && an_on_q && !settled_q)
        begin
            if (settle_cnt_q == 8'h00)
            begin
                settled_q <= 1'b1; // see RL4
            end
            else
            begin
                settle_cnt_q <= settle_cnt_q - 8'h01;
            end
        end
    end

    // Each half lasts 2*preload master clocks, one when preload is zero
    assign div_reload = (cfg_q[CFG_PRL_LSB +: CFG_PRL_W] == 5'h00) ? 6'h00
        : 6'({cfg_q[CFG_PRL_LSB +: CFG_PRL_W], 1'b0} - 6'h01);
    assign adc_tick = clk_on_q && an_on_q && (div_cnt_q == 6'h00) && !adc_clk_q;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_cnt_q <= 6'h00;
            adc_clk_q <= 1'b0;
        end
        else if (soft_rst || !an_on_q)
        begin
            div_cnt_q <= 6'h00;
            adc_clk_q <= 1'b0;
        end
        else if (clk_on_q)
        begin
            if (div_cnt_q == 6'h00)
            begin
                adc_clk_q <= !adc_clk_q; // see RL27
                div_cnt_q <= div_reload;
            end
            else
            begin
                div_cnt_q <= div_cnt_q - 6'h01;
            end
        end
    end

    // Result pins come from the analog domain
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            res_meta_q <= '0;
            res_sync_q <= '0;
        end
        else
        begin
            res_meta_q <= adc_result_i;
            res_sync_q <= res_meta_q;
        end
    end

    assign last_slot = (slot_q == cfg_q[CFG_LEN_LSB +: CFG_LEN_W]); // see RL23
    assign keep_going = cfg_q[CFG_REPEAT] && !stop_req_q
        && !(transfer_end_flag_q && cfg_q[CFG_TRANSFER_END_STOP_EN]); // see RL26
    // A full FIFO stalls the store state
    assign latch = clk_on_q && (state_q == S_STORE) && fifo_ready;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= S_IDLE;
            conv_cnt_q <= 4'h0;
            slot_q <= '0;
            stop_req_q <= 1'b0;
        end
        else if (soft_rst || an_dis_cmd)
        begin
            state_q <= S_IDLE;
            conv_cnt_q <= 4'h0;
            slot_q <= '0;
            stop_req_q <= 1'b0;
        end
        else if (clk_on_q)
        begin
            if (cmd_wr && pwdata_i[CMD_STOP] && state_q != S_IDLE)
            begin
                stop_req_q <= 1'b1; // see RL28
            end
            unique case (state_q)
                S_IDLE:
                begin
                    if (start_ok)
                    begin
                        state_q <= S_CONV; // see RL25
                        conv_cnt_q <= 4'h0;
                        slot_q <= '0;
                        stop_req_q <= 1'b0;
                    end
                end
                S_CONV:
                begin
                    if (adc_tick)
                    begin
                        conv_cnt_q <= conv_cnt_q + 4'h1; // see RL13
                        if (conv_cnt_q == 4'(CONV_CYC - 1))
                        begin
                            state_q <= S_STORE; // see RL14
                        end
                    end
                end
                S_STORE:
                begin
                    if (fifo_ready)
                    begin
                        conv_cnt_q <= 4'h0;
                        if (!last_slot)
                        begin
                            slot_q <= slot_q + 1'b1; // see RL18
                            state_q <= S_CONV;
                        end
                        else if (keep_going)
                        begin
                            slot_q <= '0; // see RL10
                            state_q <= S_CONV;
                        end
                        else
                        begin
                            state_q <= S_IDLE; // see RL11
                            stop_req_q <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // A set wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            result_q <= '0;
            done_q <= 1'b0;
            lost_q <= 1'b0;
            transfer_end_flag_q <= 1'b0;
        end
        else if (soft_rst)
        begin
            result_q <= '0;
            done_q <= 1'b0;
            lost_q <= 1'b0;
            transfer_end_flag_q <= 1'b0;
        end
        else if (clk_on_q)
        begin
            if (latch)
            begin
                result_q <= res_sync_q; // see RL14
                done_q <= 1'b1;
                if (done_q && !result_rd)
                begin
                    lost_q <= 1'b1; // see RL16
                end
            end
            else if (result_rd || start_ok)
            begin
                done_q <= 1'b0; // see RL15
            end
            if (wr_acc && paddr_i == OFF_FLAG_CLR && pwdata_i[FL_LOST]
                && !(latch && done_q && !result_rd))
            begin
                lost_q <= 1'b0; // see RL21
            end
            if (xfer_end_i)
            begin
                transfer_end_flag_q <= 1'b1; // see RL17
            end
            else if (wr_acc && paddr_i == OFF_FLAG_CLR && pwdata_i[FL_TRANSFER_END_FLAG])
            begin
                transfer_end_flag_q <= 1'b0; // see RL21
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(flags & irq_mask_q); // see RL19
        end
    end

    result_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk_i(core_clk_i),
        .rst_i(rst_i),
        .flush_i(soft_rst),
        .in_valid_i(latch),
        .in_ready_o(fifo_ready),
        .in_data_i(res_sync_q),
        .out_valid_o(result_valid_o),
        .out_ready_i(result_ready_i && clk_on_q),
        .out_data_o(result_data_o)
    );

    // Start high holds the cell in reset
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            analog_standby_o <= 1'b1;
            adc_clk_o <= 1'b0;
            adc_start_o <= 1'b1;
            adc_chan_o <= '0;
        end
        else
        begin
            analog_standby_o <= !an_on_q;
            adc_clk_o <= adc_clk_q;
            adc_start_o <= (state_q != S_CONV);
            adc_chan_o <= chan_sel[slot_q];
        end
    end

    assign prdata_o = rdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = perr_q;
    assign periph_clk_en_o = clk_on_q;
    assign irq_o = irq_q;
endmodule : adc_sequencer_control

// >>> sim/adc_ctrl_properties.sv
`timescale 1ns/1ps
module adc_ctrl_properties
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Stream and analog
    input wire logic result_valid_o,
    input wire logic result_ready_i,
    input wire logic [RES_W-1:0] result_data_o,
    input wire logic analog_standby_o,
    input wire logic adc_clk_o,
    input wire logic periph_clk_en_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence wr_s(a, b);
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == a && pwdata_i[b];
    endsequence
    AST_CLK_ON: assert property (wr_s(OFF_CLK_EN, CLK_BIT) |=> periph_clk_en_o)
        else $error("clock enable write ignored");
    AST_CLK_OFF: assert property (wr_s(OFF_CLK_DIS, CLK_BIT) |=> !periph_clk_en_o)
        else $error("clock disable write ignored");
    AST_FROZEN: assert property (!periph_clk_en_o [*3] |-> $stable(adc_clk_o))
        else $error("logic moved with clock gated");
    AST_AN_OFF: assert property (periph_clk_en_o ##0 wr_s(OFF_COMMAND, CMD_AN_DIS)
        |-> ##[1:2] analog_standby_o) else $error("analog disable ignored");
    AST_SOFT_RST: assert property (periph_clk_en_o ##0 wr_s(OFF_COMMAND, CMD_SOFT_RST)
        |-> ##[1:2] (analog_standby_o && !result_valid_o)) else $error("soft reset incomplete");
    AST_NO_CLK: assert property (analog_standby_o [*2] |-> !adc_clk_o)
        else $error("converter clock runs in standby");
    AST_BUS_ERR: assert property (psel_i && !penable_i && !(paddr_i inside {[12'h050:12'h080]})
        |=> pready_o && pslverr_o) else $error("unmapped access not flagged");
    AST_HOLD: assert property (result_valid_o && !result_ready_i && !psel_i
        |=> result_valid_o && $stable(result_data_o)) else $error("stalled word changed");
endmodule : adc_ctrl_properties

bind adc_sequencer_control adc_ctrl_properties u_props (.core_clk_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .result_valid_o,
    .result_ready_i, .result_data_o, .analog_standby_o, .adc_clk_o, .periph_clk_en_o);

// >>> sim/xfer_model.sv
`timescale 1ns/1ps
module xfer_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic stall_i,
    input wire logic [7:0] limit_i,
    output logic [7:0] pops_o,
    output logic [9:0] last_o,
    // Result stream
    input wire logic valid_i,
    input wire logic [9:0] data_i,
    output logic ready_o,
    output logic end_o
);
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ready_o <= 1'b0;
            end_o <= 1'b0;
            pops_o <= 8'h00;
            last_o <= 10'h000;
        end
        else
        begin
            ready_o <= !stall_i;
            end_o <= valid_i && ready_o && (pops_o + 8'h01 == limit_i);
            if (valid_i && ready_o)
            begin
                pops_o <= pops_o + 8'h01;
                last_o <= data_i;
            end
        end
    end
endmodule : xfer_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import adc_ctrl_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, r, sq;
    logic pslverr_o, err, result_valid_o, result_ready_i, xfer_end_i, irq_o;
    logic stall = 1'b1;
    logic [RES_W-1:0] result_data_o, last;
    logic [RES_W-1:0] adc_result_i = 10'h000;
    logic [7:0] limit = 8'hff;
    logic [7:0] pops, p0;
    int n_fail = 0, total_checks = 0, cyc = 0;
    int seed = 32'h1faf5f64;
    int len, t0;
    logic [11:0] ro [6] = '{OFF_CLK_STATE, OFF_CONFIG, OFF_SEQ_SEL, OFF_FLAG_STATE,
        OFF_IRQ_MASK, OFF_RESULT};

    always #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;

    adc_sequencer_control dut (
        .core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o(), .pslverr_o, .result_valid_o, .result_ready_i, .result_data_o, .xfer_end_i,
        .analog_standby_o(), .adc_clk_o(), .adc_start_o(), .adc_chan_o(), .adc_result_i,
        .periph_clk_en_o(), .irq_o);
    xfer_model u_xfer (.clk_i(core_clk_i), .rst_i, .stall_i(stall), .limit_i(limit),
        .pops_o(pops), .last_o(last), .valid_i(result_valid_o), .data_i(result_data_o),
        .ready_o(result_ready_i), .end_o(xfer_end_i));

    function automatic logic [31:0] cfg_word(input int n, input int rep);
        return 32'((n << CFG_LEN_LSB) | (rep << CFG_REPEAT) | (rep << CFG_TRANSFER_END_STOP_EN)
            | (SETTLE_MIN_CYC << CFG_SETTLE_LSB));
    endfunction : cfg_word

    function automatic logic [31:0] sr_word(input int n);
        return 32'h103 | ((n > 0) ? 32'h4 : 32'h0);
    endfunction : sr_word

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        @(posedge core_clk_i);
        r = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : apb

    task automatic wait_ready;
        for (int i = 0; i < 400; i++)
        begin
            apb(1'b0, OFF_FLAG_STATE, 32'h0);
            if (r[FL_READY] === 1'b1)
                break;
        end
    endtask : wait_ready

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        #2400000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        foreach (ro[i])
        begin
            apb(1'b0, ro[i], 32'h0);
            chk(r, 32'h0);
        end
        apb(1'b1, OFF_CONFIG, 32'h00080000);
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, OFF_CLK_EN, 32'h2);
        apb(1'b0, OFF_CLK_STATE, 32'h0);
        chk(r, 32'h2);
        apb(1'b0, 12'h000, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, OFF_COMMAND, 32'h8);
        apb(1'b0, OFF_FLAG_STATE, 32'h0);
        chk(r, 32'h0);
        len = $random(seed) & 7;
        apb(1'b1, OFF_CONFIG, cfg_word(len, 0));
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk(r, cfg_word(len, 0));
        sq = $random(seed) & 32'h77777777;
        apb(1'b1, OFF_SEQ_SEL, sq);
        apb(1'b0, OFF_SEQ_SEL, 32'h0);
        chk(r, sq);
        t0 = cyc;
        apb(1'b1, OFF_COMMAND, 32'h2);
        wait_ready();
        chk(cyc - t0 >= SETTLE_MIN_CYC, 1'b1);
        apb(1'b1, OFF_IRQ_EN, 32'h2);
        @(negedge core_clk_i);
        chk(irq_o, 1'b1);
        apb(1'b1, OFF_IRQ_DIS, 32'h2);
        @(negedge core_clk_i);
        chk(irq_o, 1'b0);
        adc_result_i <= 10'($random(seed));
        apb(1'b1, OFF_COMMAND, 32'h8);
        wait_ready();
        chk(r, sr_word(len));
        apb(1'b0, OFF_RESULT, 32'h0);
        chk(r, 32'(adc_result_i));
        apb(1'b1, OFF_FLAG_CLR, 32'h4);
        apb(1'b0, OFF_FLAG_STATE, 32'h0);
        chk(r, 32'h102);
        p0 = pops;
        stall <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        chk(pops - p0, len + 1);
        chk(last, adc_result_i);
        stall <= 1'b1;
        apb(1'b1, OFF_CONFIG, cfg_word(7, 1));
        apb(1'b1, OFF_COMMAND, 32'h8);
        repeat (1500) @(posedge core_clk_i);
        chk(result_valid_o, 1'b1);
        p0 = pops;
        limit <= p0 + 8'd40;
        stall <= 1'b0;
        wait_ready();
        chk({r[FL_READY], pops - p0 >= FIFO_DEPTH}, 2'b11);
        chk(r[FL_TRANSFER_END_FLAG], 1'b1);
        apb(1'b1, OFF_COMMAND, 32'h4);
        apb(1'b0, OFF_FLAG_STATE, 32'h0);
        chk(r & 32'h102, 32'h0);
        apb(1'b1, OFF_COMMAND, 32'h2);
        wait_ready();
        chk(r[FL_READY], 1'b1);
        apb(1'b1, OFF_COMMAND, 32'h1);
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, OFF_CLK_DIS, 32'h2);
        apb(1'b0, OFF_CLK_STATE, 32'h0);
        chk(r, 32'h0);
        report_and_stop();
    end
endmodule : testbench
